/* File: rtl/lsp_ctrl.v */
// Segment LCD control: sleep, bias source, reset state, pin function.
// Assumes one clk_sys; oscillator ticks arrive as synchronous pulses.
//
// What this block does
// RULE1 - control bit 6 chooses shutdown in sleep or keep running
// RULE2 - sleep with shutdown bit set stops everything at once
// RULE3 - shut down in sleep drives lowest level on all lines
// RULE4 - sleep with shutdown bit clear keeps refreshing from pixel data
// RULE5 - software picks RC or Timer1 source to display in sleep
// RULE6 - pixel data frozen while asleep
// RULE7 - reset leaves module disabled, pins default to LCD function
// RULE8 - control bit 4 set enables charge pump, else resistor ladder
// RULE9 - top rail tied to supply whenever pump is not running
// RULE10 - software programs prescale, pin function, then control fields
// RULE11 - software writes pixel data and clears frame flag next
// RULE12 - module runs only once enable bit 7 is set
// RULE13 - set group function bit overrides port direction bits
// RULE14 - writing 0x17 gives sleep-run, pump, Timer1, quad mux, disabled
// RULE15 - control bits 3:2 pick RC, Timer1 or system clock/256
// RULE16 - control bits 1:0 pick static, 1/2, 1/3, 1/4 mux
// RULE17 - frame is timing clock over 128 or 96 times prescale+1
// RULE18 - frame flag set after last pixel fetch before frame boundary
// RULE19 - pump runs only when enabled, selected, and not shut down
`include "lsp_consts.vh"

module lsp_ctrl #(
    parameter GROUPS = 8,
    parameter SEGS = 32,
    parameter COMS = 4
) (
    input wire clk_sys, // System clock, 200 MHz
    input wire srst, // Synchronous reset
    input wire ctlWe, // Control register write strobe
    input wire [7:0] ctlWdata, // Control register write data
    input wire psWe, // Prescale register write strobe
    input wire [3:0] psWdata, // Prescale write data
    input wire seWe, // Segment function write strobe
    input wire [GROUPS-1:0] seWdata, // Segment function write data
    input wire pixWe, // Pixel data write strobe
    input wire [3:0] pixAddr, // Pixel register index
    input wire [7:0] pixWdata, // Pixel write data
    input wire flagClr, // Frame flag clear pulse
    input wire coreSleep, // Core is asleep, level
    input wire rcTick, // Internal RC oscillator edge pulse
    input wire t1Tick, // Timer1 oscillator edge pulse
    input wire [GROUPS-1:0] portDir, // Port direction bits per group
    output reg [7:0] ctlRd, // Control register readback
    output reg [3:0] psRd, // Prescale readback
    output reg [GROUPS-1:0] seRd, // Segment function readback
    output reg frameFlag, // Frame flag, sticky
    output reg pumpOn, // Charge pump run
    output reg railTie, // Top rail tied to supply
    output reg rcOscOn, // RC oscillator power request
    output reg [GROUPS-1:0] pinLcd, // Group drives glass
    output reg [GROUPS-1:0] pinDir, // Effective port direction
    output reg [COMS-1:0] comActive, // Common lines in use
    output reg [1:0] comPhase, // Common currently driven
    output reg [SEGS-1:0] segData, // Segment pixel bits this phase
    output reg lvlMin // Force lowest level on all lines
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [7:0] ctl_r;
    reg [3:0] ps_r;
    reg [GROUPS-1:0] se_r;
    reg [7:0] pix_r [0:15];
    reg [1:0] phase_r;
    reg [8:0] sysCnt_r;
    reg sysTick_r;
    reg fetchDone_r;

    wire enBit = ctl_r[`LSP_CTL_EN_BIT];
    wire slpBit = ctl_r[`LSP_CTL_SLP_BIT];
    wire pumpSel = ctl_r[`LSP_CTL_PUMP_BIT];
    wire [1:0] csSel = ctl_r[`LSP_CTL_CS_HI:`LSP_CTL_CS_LO];
    wire [1:0] muxSel = ctl_r[`LSP_CTL_MUX_HI:`LSP_CTL_MUX_LO];
    // Halted: shutdown bit set and core asleep
    wire halted = coreSleep & slpBit; // RULE2
    wire running = enBit & ~halted; // RULE12
    wire [1:0] lastPhase = muxSel; // RULE16

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Writes accepted only while awake; a sleeping core cannot write
    always @(posedge clk_sys) begin
        if (srst) begin
            ctl_r <= `LSP_CTL_RST; // RULE7
            ps_r <= `LSP_PS_RST;
            se_r <= {GROUPS{1'b1}}; // RULE7
        end else if (!coreSleep) begin
            if (ctlWe)
                ctl_r <= ctlWdata; // RULE14 RULE1 RULE8
            if (psWe)
                ps_r <= psWdata;
            if (seWe)
                se_r <= seWdata;
        end
    end

    // Pixel storage is not reset; frozen during sleep
    always @(posedge clk_sys) begin
        if (pixWe && !coreSleep)
            pix_r[pixAddr] <= pixWdata; // RULE6
    end

    // ------------------------------------------------------------
    // Timing source
    // ------------------------------------------------------------
    // System clock stops in sleep, so no ticks from it then
    always @(posedge clk_sys) begin
        if (srst) begin
            sysCnt_r <= 9'd0;
            sysTick_r <= 1'b0;
        end else begin
            sysTick_r <= 1'b0;
            if (!coreSleep) begin
                if (sysCnt_r == `LSP_SYS_DIV - 9'd1) begin
                    sysCnt_r <= 9'd0;
                    sysTick_r <= 1'b1;
                end else begin
                    sysCnt_r <= sysCnt_r + 9'd1;
                end
            end
        end
    end

    reg srcTick;
    always @* begin
        case (csSel) // RULE15
            `LSP_CS_SYS: srcTick = sysTick_r; // RULE5
            `LSP_CS_T1: srcTick = t1Tick;
            default: srcTick = rcTick;
        endcase
    end

    // ------------------------------------------------------------
    // Frame timing: phase length = (ps+1) * 128/n or 96/3
    // ------------------------------------------------------------
    // Per-phase divider; whole frame is 128 or 96 times (ps+1)
    reg [7:0] phaseDiv;
    always @* begin
        case (muxSel)
            `LSP_MUX_STATIC: phaseDiv = `LSP_FRAME_DIV;
            `LSP_MUX_HALF: phaseDiv = `LSP_FRAME_DIV >> 1;
            `LSP_MUX_THIRD: phaseDiv = `LSP_FRAME_DIV3 / 8'd3;
            default: phaseDiv = `LSP_FRAME_DIV >> 2;
        endcase
    end

    wire psTick;
    wire phaseTick;
    lsp_tick_div #(.WIDTH(5)) uPs (
        .clk_sys(clk_sys),
        .srst(srst),
        .clr(~running),
        .tickIn(srcTick),
        .divisor({1'b0, ps_r} + 5'd1),
        .tickOut(psTick)
    ); // RULE17
    lsp_tick_div #(.WIDTH(8)) uPhase (
        .clk_sys(clk_sys),
        .srst(srst),
        .clr(~running),
        .tickIn(psTick),
        .divisor(phaseDiv),
        .tickOut(phaseTick)
    ); // RULE17

    // Phase counter steps commons; keeps going in sleep if allowed
    always @(posedge clk_sys) begin
        if (srst || !running) begin
            phase_r <= 2'd0;
            fetchDone_r <= 1'b0;
        end else begin
            fetchDone_r <= 1'b0;
            if (phaseTick) begin
                if (phase_r >= lastPhase) begin
                    phase_r <= 2'd0;
                end else begin
                    phase_r <= phase_r + 2'd1;
                    // Last phase data now fetched ahead of boundary
                    if (phase_r + 2'd1 == lastPhase)
                        fetchDone_r <= 1'b1; // RULE18
                end
            end else if (lastPhase == 2'd0 && psTick
                         && phase_r == 2'd0) begin
                fetchDone_r <= 1'b0;
            end
        end
    end

    // Static mode: flag once per frame on wrap of the single phase
    wire frameEvt = fetchDone_r | (phaseTick & (lastPhase == 2'd0));

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    reg [SEGS-1:0] segNxt;
    always @* begin
        segNxt = {pix_r[{phase_r, 2'd3}], pix_r[{phase_r, 2'd2}],
                  pix_r[{phase_r, 2'd1}], pix_r[{phase_r, 2'd0}]};
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            frameFlag <= 1'b0;
            pumpOn <= 1'b0;
            railTie <= 1'b1;
            rcOscOn <= 1'b0;
            pinLcd <= {GROUPS{1'b1}};
            pinDir <= {GROUPS{1'b1}};
            comActive <= {COMS{1'b0}};
            comPhase <= 2'd0;
            segData <= {SEGS{1'b0}};
            lvlMin <= 1'b1;
            ctlRd <= `LSP_CTL_RST;
            psRd <= `LSP_PS_RST;
            seRd <= {GROUPS{1'b1}};
        end else begin
            // Set wins over a clear in the same cycle
            if (running && frameEvt)
                frameFlag <= 1'b1; // RULE18
            else if (flagClr)
                frameFlag <= 1'b0;
            pumpOn <= running & pumpSel; // RULE19 RULE8
            railTie <= ~(running & pumpSel); // RULE9
            // Both upper source codes pick RC, so both power it
            rcOscOn <= running & (csSel != `LSP_CS_SYS)
                       & (csSel != `LSP_CS_T1); // RULE15
            pinLcd <= se_r;
            // Group bit set forces driver, direction ignored
            pinDir <= portDir & ~se_r; // RULE13
            comActive <= running ? ({COMS{1'b1}} >> (2'd3 - lastPhase))
                                 : {COMS{1'b0}};
            comPhase <= running ? phase_r : 2'd0;
            // Keep refreshing from stored pixels when enabled and not halted
            segData <= running ? segNxt : {SEGS{1'b0}}; // RULE4
            lvlMin <= ~running; // RULE3
            ctlRd <= ctl_r;
            psRd <= ps_r;
            seRd <= se_r;
        end
    end
endmodule

/* File: rtl/lsp_consts.vh */
// Constants for the segment display sleep/power control block.
// Assumes inclusion by bare name from design files only.
`ifndef LSP_CONSTS_VH
`define LSP_CONSTS_VH

// Display control register bit positions
`define LSP_CTL_EN_BIT 7
`define LSP_CTL_SLP_BIT 6
`define LSP_CTL_PUMP_BIT 4
`define LSP_CTL_CS_HI 3
`define LSP_CTL_CS_LO 2
`define LSP_CTL_MUX_HI 1
`define LSP_CTL_MUX_LO 0
`define LSP_CTL_RST 8'h00

// Prescale field
`define LSP_PS_HI 3
`define LSP_PS_LO 0
`define LSP_PS_RST 4'h0

// Segment function register reset: all groups drive the glass
`define LSP_SE_RST 8'hFF

// Timing source codes
`define LSP_CS_SYS 2'h0
`define LSP_CS_T1 2'h1
`define LSP_CS_RC 2'h2

// Multiplex codes
`define LSP_MUX_STATIC 2'h0
`define LSP_MUX_HALF 2'h1
`define LSP_MUX_THIRD 2'h2
`define LSP_MUX_QUARTER 2'h3

// Dividers
`define LSP_SYS_DIV 9'd256
`define LSP_FRAME_DIV 8'd128
`define LSP_FRAME_DIV3 8'd96

// Level code for the lowest LCD voltage
`define LSP_LVL_MIN 2'h0

`endif

/* File: rtl/lsp_tick_div.v */
// Divider producing a one-cycle enable every DIV input enables.
// Assumes clk_sys and synchronous active-high reset.
`include "lsp_consts.vh"

module lsp_tick_div #(
    parameter WIDTH = 9
) (
    input wire clk_sys, // System clock
    input wire srst, // Synchronous reset
    input wire clr, // Restart the count
    input wire tickIn, // Input enable
    input wire [WIDTH-1:0] divisor, // Division ratio, at least one
    output reg tickOut // One-cycle output enable
);
    reg [WIDTH-1:0] cnt_r;

    // Count input enables, pulse on wrap
    always @(posedge clk_sys) begin
        if (srst || clr) begin
            cnt_r <= {WIDTH{1'b0}};
            tickOut <= 1'b0;
        end else begin
            tickOut <= 1'b0;
            if (tickIn) begin
                if (cnt_r + 1'b1 >= divisor) begin
                    cnt_r <= {WIDTH{1'b0}};
                    tickOut <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    end
endmodule

/* File: tb/lsp_glass_model.sv */
// Glass panel stand-in: counts frames it sees refreshed.
// Assumes it watches the common phase and the parking level.
module lsp_glass_model (
    input wire clk_sys, // System clock
    input wire [1:0] comPhase, // Common now driven
    input wire lvlMin, // All lines parked low
    output int frames // Refreshed frames seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] lastPhase = 2'h0;
    initial frames = 0;
    // Parked lines never count, so a dark panel shows no frames
    always @(posedge clk_sys) begin
        if (!lvlMin && comPhase == 2'h0 && lastPhase != 2'h0)
            frames <= frames + 1;
        lastPhase <= comPhase;
    end
endmodule

/* File: tb/lsp_ctrl_assertions.sv */
// Checker for the display control block, top ports only.
// Assumes clk_sys and synchronous active-high srst.
module lsp_ctrl_assertions #(
    parameter GROUPS = 8
) (
    input wire clk_sys, // System clock
    input wire srst, // Sync reset
    input wire coreSleep, // Core asleep
    input wire flagClr, // Flag clear
    input wire [GROUPS-1:0] portDir, // Port direction
    input wire [7:0] ctlRd, // Control readback
    input wire [GROUPS-1:0] seRd, // Function readback
    input wire frameFlag, // Frame flag
    input wire pumpOn, // Pump run
    input wire railTie, // Rail tied
    input wire [GROUPS-1:0] pinLcd, // Glass groups
    input wire [GROUPS-1:0] pinDir, // Direction out
    input wire [1:0] comPhase, // Common phase
    input wire lvlMin // Lowest level
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence s_slept;
        coreSleep ##1 coreSleep;
    endsequence
    property p_sleep_off;
        s_slept |-> (ctlRd[6] |-> lvlMin && !pumpOn);
    endproperty
    property p_sleep_run;
        s_slept |-> (ctlRd[7] && !ctlRd[6] |-> !lvlMin);
    endproperty
    property p_frozen;
        s_slept |=> $stable(ctlRd) && $stable(seRd);
    endproperty
    property p_reset;
        disable iff (1'b0) srst |=> ctlRd == 8'h00 && lvlMin && railTie
            && pinLcd == {GROUPS{1'b1}} && !pumpOn && !frameFlag;
    endproperty
    property p_rail;
        railTie == !pumpOn;
    endproperty
    property p_pump;
        pumpOn |-> ctlRd[7] && ctlRd[4];
    endproperty
    property p_pins;
        !$past(srst) |-> pinLcd == seRd
            && pinDir == ($past(portDir) & ~seRd);
    endproperty
    property p_off;
        !ctlRd[7] |-> lvlMin;
    endproperty
    property p_flag;
        $rose(frameFlag) |-> comPhase == ctlRd[1:0];
    endproperty
    property p_sticky;
        frameFlag && !flagClr && !$past(flagClr) |=> frameFlag;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("module still active in shutdown sleep");
    a_sleep_run: assert property (p_sleep_run)
        else $error("display parked while running in sleep");
    a_frozen: assert property (p_frozen)
        else $error("settings changed while asleep");
    a_reset: assert property (p_reset)
        else $error("wrong state after reset");
    a_rail: assert property (p_rail)
        else $error("top rail tie not opposite of pump");
    a_pump: assert property (p_pump)
        else $error("pump runs without enable and select");
    a_pins: assert property (p_pins)
        else $error("pin function or direction wrong");
    a_off: assert property (p_off)
        else $error("lines driven while disabled");
    a_flag: assert property (p_flag)
        else $error("frame flag set outside last phase");
    a_sticky: assert property (p_sticky)
        else $error("frame flag dropped without clear");
endmodule
bind lsp_ctrl lsp_ctrl_assertions #(.GROUPS(GROUPS)) lsp_ctrl_assertions_i (
    .clk_sys(clk_sys), .srst(srst), .coreSleep(coreSleep),
    .flagClr(flagClr), .portDir(portDir), .ctlRd(ctlRd), .seRd(seRd),
    .frameFlag(frameFlag), .pumpOn(pumpOn), .railTie(railTie),
    .pinLcd(pinLcd), .pinDir(pinDir), .comPhase(comPhase), .lvlMin(lvlMin));

/* File: tb/tb_lsp_ctrl.sv */
// Self-checking bench for the display control block.
// Assumes glass model and checker compile first; Timer1 ticks fast.
module tb_lsp_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam CTL = 4'h8, PS = 4'h4, SE = 4'h2, PX = 4'h1;
    logic clk_sys = 1'b0, srst = 1'b1, coreSleep = 1'b0;
    logic ctlWe = 0, psWe = 0, seWe = 0, pixWe = 0, flagClr = 0;
    logic rcTick = 0, t1Tick = 0;
    logic [7:0] wdat = 8'h00, portDir = 8'h00, se;
    logic [3:0] pixAddr = 4'h0, psRd, comActive;
    logic [7:0] ctlRd, seRd, pinLcd, pinDir;
    logic [1:0] comPhase;
    logic [31:0] segData;
    logic frameFlag, pumpOn, railTie, lvlMin, rcOscOn;
    logic [7:0] pix [16];
    int err_total = 0, tests_run = 0, frames, f0, n, t;
    lsp_ctrl lsp_ctrl_i (.clk_sys(clk_sys), .srst(srst), .ctlWe(ctlWe),
        .ctlWdata(wdat), .psWe(psWe), .psWdata(wdat[3:0]), .seWe(seWe),
        .seWdata(wdat), .pixWe(pixWe), .pixAddr(pixAddr), .pixWdata(wdat),
        .flagClr(flagClr), .coreSleep(coreSleep), .rcTick(rcTick),
        .t1Tick(t1Tick), .portDir(portDir), .ctlRd(ctlRd), .psRd(psRd),
        .seRd(seRd), .frameFlag(frameFlag), .pumpOn(pumpOn),
        .railTie(railTie), .rcOscOn(rcOscOn), .pinLcd(pinLcd),
        .pinDir(pinDir),
        .comActive(comActive), .comPhase(comPhase), .segData(segData),
        .lvlMin(lvlMin));
    lsp_glass_model lsp_glass_model_i (.clk_sys(clk_sys),
        .comPhase(comPhase), .lvlMin(lvlMin), .frames(frames));
    // ----
    // Clock, oscillator ticks and helpers
    // ----
    always #2.5 clk_sys = ~clk_sys;
    // Ticks every other cycle keep frames short
    always @(posedge clk_sys) begin
        t1Tick <= ~t1Tick;
        rcTick <= ~rcTick;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("tests=%0d errors=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Outputs land one edge after the write is taken
    task automatic put(input logic [3:0] we, input logic [7:0] d,
                       input logic [3:0] a);
        @(posedge clk_sys);
        {ctlWe, psWe, seWe, pixWe} <= we;
        wdat <= d;
        pixAddr <= a;
        @(posedge clk_sys);
        {ctlWe, psWe, seWe, pixWe} <= 4'h0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic waitph(input logic [1:0] p, output int k);
        k = 0;
        while (comPhase !== p && k < 4000) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        if (k >= 4000) begin
            err_total++;
            close_out();
        end
    endtask
    function automatic logic [31:0] expSeg(input int p);
        return {pix[p*4+3], pix[p*4+2], pix[p*4+1], pix[p*4]};
    endfunction
    task automatic segs();
        for (int p = 0; p < 4; p++) begin
            waitph(p[1:0], n);
            @(posedge clk_sys);
            #1;
            chk(segData, expSeg(p));
        end
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        void'($urandom(32'h2d40));
        portDir <= $urandom;
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk({ctlRd, psRd, seRd, pinLcd}, 28'h000_ffff);
        chk({lvlMin, railTie, pumpOn, frameFlag}, 4'hc);
        $display("test reset done");
        put(PS, 8'h01, 4'h0);
        chk(psRd, 4'h1);
        se = $urandom;
        put(SE, se, 4'h0);
        chk({pinLcd, pinDir}, {se, portDir & ~se});
        put(CTL, 8'h17, 4'h0);
        chk({ctlRd, pumpOn, railTie, lvlMin}, 11'h0bb);
        for (int i = 0; i < 16; i++) begin
            pix[i] = $urandom;
            put(PX, pix[i], i[3:0]);
        end
        put(CTL, 8'h97, 4'h0);
        chk({pumpOn, railTie, lvlMin}, 3'h4);
        segs();
        repeat (4) @(posedge clk_sys);
        #1;
        chk(frameFlag, 1'b1);
        @(posedge clk_sys);
        flagClr <= 1'b1;
        @(posedge clk_sys);
        flagClr <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk(frameFlag, 1'b0);
        t = 0;
        waitph(2'h0, n);
        for (int p = 1; p < 5; p++) begin
            waitph(p[1:0], n);
            t += n;
        end
        chk(t, 512);
        $display("test run done");
        // Timer1 source keeps frames going while the core sleeps
        @(posedge clk_sys);
        coreSleep <= 1'b1;
        f0 = frames;
        put(PX, ~pix[0], 4'h0);
        put(CTL, 8'h00, 4'h0);
        segs();
        segs();
        chk({ctlRd, lvlMin}, 9'h12e);
        chk(frames > f0, 1'b1);
        @(posedge clk_sys);
        coreSleep <= 1'b0;
        put(CTL, 8'hd7, 4'h0);
        @(posedge clk_sys);
        coreSleep <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk({lvlMin, pumpOn, railTie}, 3'h5);
        @(posedge clk_sys);
        coreSleep <= 1'b0;
        $display("test sleep done");
        // Every source and multiplex code, ladder bias
        for (int m = 0; m < 16; m++) begin
            put(CTL, {4'h8, m[3:0]}, 4'h0);
            chk({comActive, pumpOn, railTie, rcOscOn},
                {4'hf >> (2'd3 - m[1:0]), 2'b01, m[3]});
        end
        $display("test modes done");
        close_out();
    end
endmodule
